// ---- hw/fifo_host_pkg.sv ----
// constants shared by the external fifo host controller
// assumes a 100 MHz clk_sys driving the strobe sequencer
package fifo_host_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned WORD_W        = 9;
   localparam int unsigned DEPTH         = 512;
   localparam int unsigned PTR_W         = 10;
   // strobe timing in ns (slowest grade)
   localparam int unsigned PULSE_NS      = 65;
   localparam int unsigned RECOVERY_NS   = 15;
   localparam int unsigned SETUP_NS      = 30;
   localparam int unsigned FLAG_NS       = 60;
   localparam int unsigned ACCESS_NS     = 65;
   localparam int unsigned MR_HIGH_NS    = 65;
   // least times round up
   localparam int unsigned PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RECOVERY_CYC  = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FLAG_CYC      = (FLAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned MR_HIGH_CYC   = (MR_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W         = 4;
   localparam logic [WORD_W-1:0] DATA_RST = 9'h000;
   localparam logic [1:0]        BUF_DEPTH = 2'h2;
endpackage

// ---- hw/skid_buf2.sv ----
// two-entry valid/ready buffer for read words
// assumes one clock, source and sink on clk_sys
`timescale 1ns/1ns
module skid_buf2 (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // fill side
   input  wire logic        in_valid,
   output logic             in_ready,
   input  wire logic [8:0]  in_data,
   // drain side
   output logic             out_valid,
   input  wire logic        out_ready,
   output logic [8:0]       out_data
);
   logic [8:0] mem_q [2];
   logic [8:0] mem_d [2];
   logic       wr_q, wr_d, rd_q, rd_d;
   logic [1:0] cnt_q, cnt_d;

   always_comb begin
      logic push;
      logic pop;
      push  = in_valid && (cnt_q != fifo_host_pkg::BUF_DEPTH);
      pop   = out_ready && (cnt_q != 2'h0);
      mem_d = mem_q;
      wr_d  = wr_q;
      rd_d  = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = in_data;
         wr_d        = ~wr_q;
      end
      if (pop) begin
         rd_d = ~rd_q;
      end
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mem_q[0] <= fifo_host_pkg::DATA_RST;
         mem_q[1] <= fifo_host_pkg::DATA_RST;
         wr_q     <= 1'b0;
         rd_q     <= 1'b0;
         cnt_q    <= 2'h0;
      end else begin
         mem_q <= mem_d;
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   assign in_ready  = (cnt_q != fifo_host_pkg::BUF_DEPTH);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data  = mem_q[rd_q];
endmodule

// ---- hw/fifo_host.sv ----
// host controller driving the strobe pins of an asynchronous 9-bit fifo
// assumes fifo pins arrive asynchronously; user side on clk_sys
// Summary of operation
// - host applies master reset first, strobes high around its rising edge
// - host holds both strobes high during rewind and its recovery
// - standalone mode: chain input low, first load high
// - depth mode: chain ring, first-loaded device has first load low
// - depth mode needs per-device flags or-ed; host is standalone only and ors nothing; no half or rewind
`timescale 1ns/1ns
module fifo_host (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // user commands
   input  wire logic        reset_req,
   input  wire logic        rewind_req,
   input  wire logic        wr_valid,
   input  wire logic [8:0]  wr_data,
   output logic             wr_ready,
   input  wire logic        rd_req,
   output logic             busy,
   // read data stream
   output logic             rd_valid,
   input  wire logic        rd_ready,
   output logic [8:0]       rd_data,
   // status
   output logic             fifo_empty,
   output logic             fifo_half,
   output logic             fifo_full,
   // fifo pins
   output logic             write_strobe_n,
   output logic             read_strobe_n,
   output logic [8:0]       fifo_din,
   input  wire logic [8:0]  fifo_dout,
   output logic             master_reset_n,
   output logic             rewind_n,
   output logic             chain_in_n,
   output logic             first_load_select_n,
   input  wire logic        empty_flag_n,
   input  wire logic        half_full_flag_n,
   input  wire logic        full_flag_n
);
   typedef enum {ST_INIT, ST_IDLE, ST_MR_LOW, ST_MR_REC, ST_WR_LOW, ST_WR_REC,
                 ST_RD_LOW, ST_RD_REC, ST_RT_LOW, ST_RT_REC} state_t;
   localparam logic [3:0] C_PULSE = 4'(fifo_host_pkg::PULSE_CYC);
   localparam logic [3:0] C_REC   = 4'(fifo_host_pkg::RECOVERY_CYC);
   localparam logic [3:0] C_FLAG  = 4'(fifo_host_pkg::FLAG_CYC);
   localparam logic [3:0] C_ACC   = 4'(fifo_host_pkg::ACCESS_CYC);
   localparam logic [3:0] C_MRH   = 4'(fifo_host_pkg::MR_HIGH_CYC);

   state_t     st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic       w_q, w_d, r_q, r_d, mr_q, mr_d, rt_q, rt_d, busy_q, busy_d;
   logic [8:0] din_q, din_d, cap_q, cap_d;
   logic       cap_v_q, cap_v_d;
   logic [2:0] f1_q, f2_q;
   logic [2:0] st_fl_q, st_fl_d;
   logic       wr_rdy_q, wr_rdy_d;
   logic [8:0] q1_q, q2_q;
   logic       buf_ready;

   // two-flop synchronisers on pin inputs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         f1_q <= 3'h3;
         f2_q <= 3'h3;
         q1_q <= 9'h000;
         q2_q <= 9'h000;
      end else begin
         f1_q <= {empty_flag_n, half_full_flag_n, full_flag_n};
         f2_q <= f1_q;
         q1_q <= fifo_dout;
         q2_q <= q1_q;
      end
   end

   // f2_q: [2]=empty_n [1]=half_n [0]=full_n
   always_comb begin
      st_d    = st_q;
      cnt_d   = (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
      w_d     = w_q;
      r_d     = r_q;
      mr_d    = mr_q;
      rt_d    = rt_q;
      din_d   = din_q;
      cap_d   = cap_q;
      cap_v_d = 1'b0;
      st_fl_d = ~f2_q;
      busy_d  = 1'b1;
      case (st_q)
         ST_INIT: begin
            st_d  = ST_MR_LOW;
            mr_d  = 1'b0;
            cnt_d = C_PULSE;
         end
         ST_IDLE: begin
            busy_d = 1'b0;
            if (reset_req) begin
               st_d   = ST_MR_LOW;
               mr_d   = 1'b0;
               cnt_d  = C_PULSE;
               busy_d = 1'b1;
            end else if (rewind_req) begin
               st_d   = ST_RT_LOW;
               rt_d   = 1'b0;
               cnt_d  = C_PULSE;
               busy_d = 1'b1;
            end else if (wr_valid && f2_q[0]) begin
               st_d   = ST_WR_LOW;
               w_d    = 1'b0;
               din_d  = wr_data;
               cnt_d  = (C_PULSE > C_ACC) ? C_PULSE : C_ACC;
               busy_d = 1'b1;
            end else if (rd_req && f2_q[2] && buf_ready) begin
               st_d   = ST_RD_LOW;
               r_d    = 1'b0;
               cnt_d  = C_ACC + 4'h2;
               busy_d = 1'b1;
            end
         end
         ST_MR_LOW: if (cnt_q == 4'h0) begin
            st_d  = ST_MR_REC;
            mr_d  = 1'b1; // strobes stay high through recovery
            cnt_d = C_MRH + C_FLAG;
         end
         ST_WR_LOW: if (cnt_q == 4'h0) begin
            st_d  = ST_WR_REC;
            w_d   = 1'b1;
            cnt_d = C_REC + C_FLAG;
         end
         ST_RD_LOW: if (cnt_q == 4'h0) begin
            cap_d   = q2_q;
            cap_v_d = 1'b1;
            st_d    = ST_RD_REC;
            r_d     = 1'b1;
            cnt_d   = C_REC + C_FLAG;
         end
         ST_RT_LOW: if (cnt_q == 4'h0) begin
            st_d  = ST_RT_REC;
            rt_d  = 1'b1;
            cnt_d = C_REC + C_FLAG; // flags settle
         end
         ST_MR_REC, ST_WR_REC, ST_RD_REC, ST_RT_REC: if (cnt_q == 4'h0) begin
            st_d = ST_IDLE;
         end
         default: st_d = ST_INIT;
      endcase
      wr_rdy_d = ~busy_d & ~st_fl_d[0];
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q    <= ST_INIT;
         cnt_q   <= 4'h0;
         w_q     <= 1'b1;
         r_q     <= 1'b1;
         mr_q    <= 1'b1;
         rt_q    <= 1'b1;
         busy_q  <= 1'b1;
         din_q   <= fifo_host_pkg::DATA_RST;
         cap_q   <= fifo_host_pkg::DATA_RST;
         cap_v_q <= 1'b0;
         st_fl_q <= 3'h4; // reads as empty, not half, not full
         wr_rdy_q <= 1'b0;
      end else begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         w_q     <= w_d;
         r_q     <= r_d;
         mr_q    <= mr_d;
         rt_q    <= rt_d;
         busy_q  <= busy_d;
         din_q   <= din_d;
         cap_q   <= cap_d;
         cap_v_q <= cap_v_d;
         st_fl_q <= st_fl_d;
         wr_rdy_q <= wr_rdy_d;
      end
   end

   skid_buf2 u_rd_buf (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (cap_v_q),
      .in_ready  (buf_ready),
      .in_data   (cap_q),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (rd_data)
   );

   assign write_strobe_n      = w_q;
   assign read_strobe_n       = r_q;
   assign master_reset_n      = mr_q;
   assign rewind_n            = rt_q;
   assign fifo_din            = din_q;
   assign busy                = busy_q;
   assign wr_ready            = wr_rdy_q;
   assign fifo_empty          = st_fl_q[2];
   assign fifo_half           = st_fl_q[1];
   assign fifo_full           = st_fl_q[0];
   assign chain_in_n          = 1'b0; // standalone strap, no ring
   assign first_load_select_n = 1'b1; // one device: flags need no or-ing

   a_mr_strobes: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!mr_q || st_q == ST_MR_REC) |-> (w_q && r_q)) else $error("strobe low in reset");
   a_rt_strobes: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!rt_q || st_q == ST_RT_REC) |-> (w_q && r_q)) else $error("strobe low in rewind");
   a_no_full_wr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_q == ST_IDLE && !f2_q[0]) |=> w_q) else $error("write into full fifo");
   a_no_empty_rd: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_q == ST_IDLE && !f2_q[2]) |=> r_q) else $error("read from empty fifo");
   a_wr_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(w_q) |-> !w_q [*7]) else $error("write pulse too short");
   // read strobe stays low ten samples
   sequence s_rd_low;
      !r_q [*5] ##1 !r_q [*5];
   endsequence
   a_rd_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(r_q) |-> s_rd_low ##1 r_q) else $error("read pulse length wrong");
   a_rd_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(r_q) |-> cap_v_q && (cap_q == $past(q2_q))) else $error("read word not captured");
   a_straps: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !chain_in_n && first_load_select_n) else $error("mode straps wrong");
endmodule

// ---- testbench/fifo_dev_model.sv ----
// behavioural model of the asynchronous 9-bit fifo device, standalone mode
// assumes a host driving active-low strobes; fault_cnt counts host misuse
`timescale 1ns/1ns
module fifo_dev_model #(
   parameter int DEPTH = 256
) (
   // strobes and straps
   input  wire logic       write_strobe_n,
   input  wire logic       read_strobe_n,
   input  wire logic       master_reset_n,
   input  wire logic       rewind_n,
   input  wire logic       chain_in_n,
   input  wire logic       first_load_select_n,
   // data
   input  wire logic [8:0] fifo_din,
   output logic [8:0]      fifo_dout,
   // flags and misuse count
   output logic            empty_flag_n,
   output logic            half_full_flag_n,
   output logic            full_flag_n,
   output int              fault_cnt
);
   logic [8:0] mem [DEPTH];
   int         wp = 0;
   int         rp = 0;
   int         cnt = 0;
   bit         pw = 0;
   bit         pr = 0;
   initial fault_cnt = 0;
   initial fifo_dout = 9'h155;
   always_comb begin
      empty_flag_n     = (cnt - pr) != 0;
      half_full_flag_n = !(cnt + pw > DEPTH / 2);
      full_flag_n      = !(cnt + pw == DEPTH);
   end
   always @(negedge master_reset_n) begin
      wp = 0;
      rp = 0;
      cnt = 0;
   end
   always @(posedge master_reset_n)
      if (!write_strobe_n || !read_strobe_n || chain_in_n || !first_load_select_n) fault_cnt++;
   always @(negedge write_strobe_n or negedge read_strobe_n)
      if (!rewind_n || !master_reset_n) fault_cnt++;
   always @(negedge write_strobe_n)
      pw = full_flag_n;
   always @(posedge write_strobe_n) begin
      if (pw) begin
         mem[wp % DEPTH] = fifo_din;
         wp++;
         cnt++;
      end
      pw = 0;
   end
   always @(negedge read_strobe_n) begin
      pr = empty_flag_n;
      if (pr) fifo_dout = mem[rp % DEPTH];
   end
   // released bus shows no stable value
   always @(posedge read_strobe_n) begin
      if (pr) begin
         rp++;
         cnt--;
      end
      pr = 0;
      fifo_dout = ~fifo_dout;
   end
   always @(negedge rewind_n) begin
      rp = 0;
      cnt = wp;
      if (!write_strobe_n || !read_strobe_n) fault_cnt++;
   end
endmodule

// ---- testbench/test_fifo_host.sv ----
// self-checking bench for the fifo host controller
// assumes the device model on the pins and a 100 MHz clk_sys
`timescale 1ns/1ns
module test_fifo_host;
   localparam int DEPTH = 256;
   logic       clk_sys, rst_n, reset_req, rewind_req, wr_valid, rd_req, rd_ready;
   logic [8:0] wr_data, rd_data, fifo_din, fifo_dout;
   logic       wr_ready, busy, rd_valid, fifo_empty, fifo_half, fifo_full;
   logic       ws_n, rs_n, mr_n, rw_n, ci_n, fl_n, ef_n, hf_n, ff_n;
   int         err_count, samples_checked, faults, wr_falls, rd_falls;
   fifo_host i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reset_req(reset_req), .rewind_req(rewind_req),
      .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_req(rd_req), .busy(busy),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .fifo_empty(fifo_empty),
      .fifo_half(fifo_half), .fifo_full(fifo_full), .write_strobe_n(ws_n), .read_strobe_n(rs_n),
      .fifo_din(fifo_din), .fifo_dout(fifo_dout), .master_reset_n(mr_n), .rewind_n(rw_n), .chain_in_n(ci_n),
      .first_load_select_n(fl_n), .empty_flag_n(ef_n), .half_full_flag_n(hf_n), .full_flag_n(ff_n));
   fifo_dev_model #(.DEPTH(DEPTH)) i_dev (.write_strobe_n(ws_n), .read_strobe_n(rs_n), .master_reset_n(mr_n),
      .rewind_n(rw_n), .chain_in_n(ci_n), .first_load_select_n(fl_n), .fifo_din(fifo_din),
      .fifo_dout(fifo_dout), .empty_flag_n(ef_n), .half_full_flag_n(hf_n), .full_flag_n(ff_n),
      .fault_cnt(faults));
   initial begin
      clk_sys = 0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(negedge ws_n) wr_falls++;
   always @(negedge rs_n) rd_falls++;
   task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic idle();
      int n;
      n = 0;
      @(negedge clk_sys);
      while (busy !== 1'b0 && n < 400) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 400) chk("busy", 9'h000, {8'h00, busy});
   endtask
   // kind: 0 reset, 1 rewind, 2 write, 3 read
   task automatic req(input int k, input logic [8:0] d);
      idle();
      case (k)
         0: reset_req = 1;
         1: rewind_req = 1;
         2: begin
            wr_valid = 1;
            wr_data = d;
         end
         default: rd_req = 1;
      endcase
      @(negedge clk_sys);
      {reset_req, rewind_req, wr_valid, rd_req} = 4'h0;
      idle();
   endtask
   task automatic pop(input logic [8:0] exp);
      chk("rd_valid", 9'h001, {8'h00, rd_valid});
      chk("rd_data", exp, rd_data);
      rd_ready = 1;
      @(negedge clk_sys);
      rd_ready = 0;
   endtask
   task automatic rd(input logic [8:0] exp);
      req(3, 9'h000);
      pop(exp);
   endtask
   task automatic t_reset();
      int f;
      f = rd_falls;
      idle();
      chk("flags", 9'h004, {6'h00, fifo_empty, fifo_half, fifo_full});
      chk("straps", 9'h001, {7'h00, ci_n, fl_n});
      req(3, 9'h000);
      chk("refused read", 9'(f), 9'(rd_falls));
      chk("rd_valid", 9'h000, {8'h00, rd_valid});
   endtask
   task automatic t_order();
      req(2, 9'h1A5);
      chk("empty", 9'h000, {8'h00, fifo_empty});
      chk("wr_ready", 9'h001, {8'h00, wr_ready});
      req(2, 9'h05A);
      req(2, 9'h1FF);
      rd(9'h1A5);
      rd(9'h05A);
      rd(9'h1FF);
      chk("empty", 9'h001, {8'h00, fifo_empty});
   endtask
   task automatic t_rewind();
      req(1, 9'h000);
      rd(9'h1A5);
      req(2, 9'h0C3);
      rd(9'h05A);
      rd(9'h1FF);
      rd(9'h0C3);
      chk("empty", 9'h001, {8'h00, fifo_empty});
   endtask
   task automatic t_fill();
      int f;
      req(0, 9'h000);
      chk("flags", 9'h004, {6'h00, fifo_empty, fifo_half, fifo_full});
      for (int i = 0; i < DEPTH; i++) begin
         req(2, 9'(i));
         chk("half", 9'(i + 1 > DEPTH / 2), {8'h00, fifo_half});
      end
      chk("full", 9'h001, {8'h00, fifo_full});
      chk("wr_ready", 9'h000, {8'h00, wr_ready});
      f = wr_falls;
      req(2, 9'h1EE);
      chk("refused write", 9'(f), 9'(wr_falls));
      rd(9'h000);
      chk("full", 9'h000, {8'h00, fifo_full});
      chk("wr_ready", 9'h001, {8'h00, wr_ready});
      for (int i = 1; i < DEPTH / 2 - 1; i++) rd(9'(i));
      chk("half", 9'h001, {8'h00, fifo_half});
      rd(9'(DEPTH / 2 - 1));
      chk("half", 9'h000, {8'h00, fifo_half});
   endtask
   task automatic t_stall();
      int f;
      req(3, 9'h000);
      req(3, 9'h000);
      f = rd_falls;
      req(3, 9'h000);
      chk("stalled read", 9'(f), 9'(rd_falls));
      pop(9'(DEPTH / 2));
      pop(9'(DEPTH / 2 + 1));
      chk("rd_valid", 9'h000, {8'h00, rd_valid});
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk_sys);
      err_count++;
      stop_test();
   end
   initial begin
      {rst_n, reset_req, rewind_req, wr_valid, rd_req, rd_ready} = 6'h00;
      err_count = 0;
      samples_checked = 0;
      wr_falls = 0;
      rd_falls = 0;
      wr_data = 9'h000;
      repeat (8) @(negedge clk_sys);
      rst_n = 1;
      t_reset();
      t_order();
      t_rewind();
      t_fill();
      t_stall();
      chk("misuse", 9'h000, 9'(faults));
      stop_test();
   end
endmodule
